// *** dacc_chan.sv ***
// One converter channel: two's-complement coding and sample averaging
`default_nettype none
module dacc_chan #(
    parameter int RES = 16
) (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Control from the sequencer
    input  wire logic                  done_i,
    input  wire logic                  last_i,
    input  wire logic                  clr_i,
    input  wire logic [1:0]            shift_i,
    // Raw offset-binary result of the converter
    input  wire logic [RES-1:0]        raw_i,
    // Output word
    output logic signed [RES-1:0]      data_o,
    output logic                       valid_o
);
    logic signed [RES-1:0] code;
    logic signed [RES+1:0] code_ext;
    logic signed [RES+1:0] acc_r;
    logic signed [RES+1:0] sum;
    logic signed [RES+1:0] shifted;

    // Flipping the MSB turns offset binary into two's complement
    assign code     = {~raw_i[RES-1], raw_i[RES-2:0]};  // [R06] [R07]
    assign code_ext = {{2{code[RES-1]}}, code};
    // Two guard bits: four full-scale codes cannot overflow the sum
    assign sum      = acc_r + code_ext;
    assign shifted  = sum >>> shift_i;                  // [R12]

    // ------------------------------------------------------------
    // Accumulator and output word
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            acc_r   <= '0;
            data_o  <= '0;
            valid_o <= 1'b0;
        end else begin
            valid_o <= 1'b0;
            if (done_i) begin
                if (last_i) begin
                    data_o  <= shifted[RES-1:0];        // [R09] [R12]
                    valid_o <= 1'b1;
                    acc_r   <= '0;
                end else begin
                    acc_r   <= sum;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_single_code;
        @(posedge clk_i) disable iff (rst_i || clr_i)
        (done_i && last_i && shift_i == 2'd0) |=> (valid_o && data_o == $past(code));
    endproperty
    a_single_code: assert property (p_single_code) else $error("single sample code wrong"); // [R06]

    property p_neg_full;
        @(posedge clk_i) disable iff (rst_i || clr_i)
        (done_i && last_i && shift_i == 2'd0 && raw_i == '0) |=> (data_o[RES-1] && data_o[RES-2:0] == '0);
    endproperty
    a_neg_full: assert property (p_neg_full) else $error("negative full scale code wrong"); // [R07]
endmodule
`default_nettype wire

// *** dacc_defines.svh ***
// Constants for the dual converter conversion-control block
`ifndef DACC_DEFINES_SVH
`define DACC_DEFINES_SVH

// ----------------------------------------------------------------
// Averaging select field codes and reset values
// ----------------------------------------------------------------
`define DACC_AVG_TWO        2'b10
`define DACC_AVG_FOUR       2'b11
`define DACC_AVG_CFG_RST    2'b00
`define DACC_CM_OFS_RST     1'b0

// ----------------------------------------------------------------
// Analog effect of the common-mode offset bit
// ----------------------------------------------------------------
`define DACC_CM_OFFSET_MV   100

// ----------------------------------------------------------------
// Timing: internal clock period and conversion time
// ----------------------------------------------------------------
`define DACC_CLK_PERIOD_NS  40
`define DACC_CONV_TIME_NS   320
`define DACC_CONV_CYCLES    ((`DACC_CONV_TIME_NS + `DACC_CLK_PERIOD_NS - 1) / `DACC_CLK_PERIOD_NS)

`endif

// *** dacc_host_model.sv ***
// Host controller model that drives the conversion-start pin
`default_nettype none
module dacc_host_model (
    // Clock
    input  wire logic clk_i,
    // Conversion-start pin
    output var logic  conv_start_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // Start pulses
    // ----------------------------------------------------------------
    // Pin idles low, so every pulse forms a fresh rising edge
    initial conv_start_o = 1'b0;

    // A slow host passes a larger gap; a gap of 0 fires at once
    task automatic pulse(input int gap);
        repeat (gap) @(negedge clk_i);
        conv_start_o = 1'b1;
        @(negedge clk_i);
        conv_start_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** dacc_pkg.sv ***
// Types shared by the conversion-control block
`default_nettype none
package dacc_pkg;
    // Device phases: reset/power-down, acquisition, conversion
    typedef enum logic [2:0] {
        DACC_ST_RST = 3'b001,
        DACC_ST_ACQ = 3'b010,
        DACC_ST_CNV = 3'b100
    } dacc_state_type;
endpackage
`default_nettype wire

// *** dacc_top.sv ***
// Conversion sequencer, configuration and output coding of the dual converter
// Functional notes
// [R01] Start edge launches both channels together
// [R02] Conversion timed by internal clock only
// [R03] Inputs isolated during conversion
// [R04] End of conversion reconnects, returns acquisition
// [R05] Done pulse and result to interface
// [R06] Results in two's complement, 16/14 bits
// [R07] Full-scale codes 8000/7FFF, mid 0000
// [R08] Offset bit raises half-reference by 100mV
// [R09] Optional averaging of two or four samples
// [R10] Codes 10b/11b pick two/four averaging
// [R11] Ready only after group's last start
// [R12] Four-sample output is sum over four
// [R13] Reset aborts conversion, restores configuration
// [R14] Other select codes disable averaging
`include "dacc_defines.svh"
`default_nettype none
module dacc_top #(
    parameter int RES         = 16,
    parameter int CONV_CYCLES = `DACC_CONV_CYCLES
) (
    // Clock and reset
    input  wire logic                   CLK_I,
    input  wire logic                   RST_N_I,
    // Host control pins
    input  wire logic                   CONV_START_I,
    input  wire logic                   POWERDOWN_RESET_N_I,
    // Configuration write from the interface module
    input  wire logic                   CFG_WR_I,
    input  wire logic [1:0]             CFG_AVG_SEL_I,
    input  wire logic                   CFG_CM_OFS_EN_I,
    // Raw converter results
    input  wire logic [RES-1:0]         RAW_A_I,
    input  wire logic [RES-1:0]         RAW_B_I,
    // Sampling switch and converter status
    output logic                        ISOLATE_O,
    output logic                        CONV_DONE_O,
    output dacc_pkg::dacc_state_type    STATE_O,
    // Output words
    output logic signed [RES-1:0]       DATA_A_O,
    output logic signed [RES-1:0]       DATA_B_O,
    output logic                        READY_O,
    // Configuration readback and analog trim
    output logic [1:0]                  AVG_CFG_O,
    output logic                        CM_OFFSET_EN_O
);
    import dacc_pkg::*;

    localparam int CW       = (CONV_CYCLES > 1) ? $clog2(CONV_CYCLES) : 1;
    // Analog step the trim output commands, in millivolts
    localparam int CM_OFFSET_MV = `DACC_CM_OFFSET_MV;

    dacc_state_type state_r;
    logic [CW-1:0]  cnt_r;
    logic           isolate_r;
    logic           done_r;
    logic           start_q_r;
    logic           start_rise;
    logic           in_rst;
    logic [1:0]     averaging_config_reg_r;
    logic           common_mode_offset_reg_r;
    logic [1:0]     avg_shift;
    logic [1:0]     grp_top;
    logic [1:0]     grp_r;
    logic           grp_last;
    logic           valid_a;
    logic           valid_b;
    logic           ready_r;

    // ------------------------------------------------------------
    // Reset and start edge
    // ------------------------------------------------------------
    // Power-down pin acts like reset; both are taken synchronously
    assign in_rst     = !RST_N_I || !POWERDOWN_RESET_N_I;
    assign start_rise = CONV_START_I && !start_q_r;

    // Previous level of the start pin for edge detection
    always_ff @(posedge CLK_I) begin
        if (in_rst) begin
            start_q_r <= 1'b0;
        end else begin
            start_q_r <= CONV_START_I;
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    // Counting runs on our own clock; the host only gives the edge.
    // A start edge during conversion is ignored, not queued.
    always_ff @(posedge CLK_I) begin
        if (in_rst) begin
            state_r   <= DACC_ST_RST;                         // [R13]
            cnt_r     <= '0;
            isolate_r <= 1'b0;
            done_r    <= 1'b0;
        end else begin
            done_r <= 1'b0;
            unique case (state_r)
                DACC_ST_RST: begin
                    state_r <= DACC_ST_ACQ;                   // Wake-up into acquisition
                end
                DACC_ST_ACQ: begin
                    if (start_rise) begin
                        state_r   <= DACC_ST_CNV;             // [R01]
                        isolate_r <= 1'b1;                    // [R03]
                        cnt_r     <= CW'(CONV_CYCLES - 1);    // [R02]
                    end
                end
                DACC_ST_CNV: begin
                    if (cnt_r == '0) begin
                        state_r   <= DACC_ST_ACQ;             // [R04]
                        isolate_r <= 1'b0;                    // [R04]
                        done_r    <= 1'b1;                    // [R05]
                    end else begin
                        cnt_r <= cnt_r - CW'(1);              // [R02]
                    end
                end
                default: begin
                    state_r   <= DACC_ST_RST;
                    isolate_r <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Defaults return on either reset source
    always_ff @(posedge CLK_I) begin
        if (in_rst) begin
            averaging_config_reg_r   <= `DACC_AVG_CFG_RST;    // [R13]
            common_mode_offset_reg_r <= `DACC_CM_OFS_RST;     // [R13]
        end else if (CFG_WR_I) begin
            averaging_config_reg_r   <= CFG_AVG_SEL_I;
            common_mode_offset_reg_r <= CFG_CM_OFS_EN_I;      // [R08]
        end
    end

    // Averaging factor as a shift; unknown codes mean single samples
    always_comb begin
        unique case (averaging_config_reg_r)
            `DACC_AVG_TWO: begin
                avg_shift = 2'd1;                             // [R10]
                grp_top   = 2'd1;
            end
            `DACC_AVG_FOUR: begin
                avg_shift = 2'd2;                             // [R10]
                grp_top   = 2'd3;
            end
            default: begin
                avg_shift = 2'd0;                             // [R14]
                grp_top   = 2'd0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Averaging group counter
    // ------------------------------------------------------------
    // A config change restarts the group so no mixed-mode sum is emitted
    assign grp_last = (grp_r == grp_top);

    always_ff @(posedge CLK_I) begin
        if (in_rst || CFG_WR_I) begin
            grp_r <= 2'd0;
        end else if (done_r) begin
            grp_r <= grp_last ? 2'd0 : grp_r + 2'd1;          // [R09] [R11]
        end
    end

    // ------------------------------------------------------------
    // Channels, fed by one done pulse so both sample together
    // ------------------------------------------------------------
    dacc_chan #(
        .RES (RES)
    ) u_chan_a (
        .clk_i   (CLK_I),
        .rst_i   (in_rst),
        .done_i  (done_r),                                    // [R01]
        .last_i  (grp_last),
        .clr_i   (CFG_WR_I),
        .shift_i (avg_shift),
        .raw_i   (RAW_A_I),
        .data_o  (DATA_A_O),
        .valid_o (valid_a)
    );

    dacc_chan #(
        .RES (RES)
    ) u_chan_b (
        .clk_i   (CLK_I),
        .rst_i   (in_rst),
        .done_i  (done_r),                                    // [R01]
        .last_i  (grp_last),
        .clr_i   (CFG_WR_I),
        .shift_i (avg_shift),
        .raw_i   (RAW_B_I),
        .data_o  (DATA_B_O),
        .valid_o (valid_b)
    );

    // ------------------------------------------------------------
    // Ready flag
    // ------------------------------------------------------------
    // Set wins over the clear by a new start edge in the same cycle
    always_ff @(posedge CLK_I) begin
        if (in_rst || CFG_WR_I) begin
            ready_r <= 1'b0;
        end else if (valid_a && valid_b) begin
            ready_r <= 1'b1;                                  // [R11]
        end else if (start_rise) begin
            ready_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign ISOLATE_O      = isolate_r;
    assign CONV_DONE_O    = done_r;                           // [R05]
    assign STATE_O        = state_r;
    assign READY_O        = ready_r;
    assign AVG_CFG_O      = averaging_config_reg_r;
    // High commands +CM_OFFSET_MV on the half-reference buffer
    assign CM_OFFSET_EN_O = common_mode_offset_reg_r;         // [R08]

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (in_rst);

    property p_start_cnv;
        (state_r == DACC_ST_ACQ && start_rise) |=> (state_r == DACC_ST_CNV && isolate_r);
    endproperty
    a_start_cnv: assert property (p_start_cnv) else $error("start edge did not launch conversion"); // [R01]

    // Isolation is dropped in the very cycle done shows, so test the edge, not a span
    property p_conv_len;
        $rose(isolate_r) |-> ##CONV_CYCLES (done_r && $fell(isolate_r));
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong"); // [R02]

    property p_isolate;
        (state_r == DACC_ST_CNV) |-> isolate_r;
    endproperty
    a_isolate: assert property (p_isolate) else $error("inputs not isolated in conversion"); // [R03]

    property p_reconnect;
        done_r |-> (state_r == DACC_ST_ACQ && !isolate_r && $past(state_r) == DACC_ST_CNV);
    endproperty
    a_reconnect: assert property (p_reconnect) else $error("no return to acquisition"); // [R04]

    property p_abort;
        @(posedge CLK_I) disable iff (1'b0)
        in_rst |=> (state_r == DACC_ST_RST && !isolate_r && averaging_config_reg_r == `DACC_AVG_CFG_RST);
    endproperty
    a_abort: assert property (p_abort) else $error("reset did not abort"); // [R13]

    property p_ready_last;
        $rose(ready_r) |-> $past(done_r && grp_last, 2);
    endproperty
    a_ready_last: assert property (p_ready_last) else $error("ready before group end"); // [R11]

    property p_no_avg;
        (done_r && avg_shift == 2'd0 && !CFG_WR_I) |-> ##2 ready_r;
    endproperty
    a_no_avg: assert property (p_no_avg) else $error("single sample gave no ready"); // [R14]

    c_conv: cover property (done_r && avg_shift == 2'd0);
    c_avg2: cover property ($rose(ready_r) && averaging_config_reg_r == `DACC_AVG_TWO);
    c_avg4: cover property ($rose(ready_r) && averaging_config_reg_r == `DACC_AVG_FOUR);
endmodule
`default_nettype wire

// *** tb_dacc_top.sv ***
// Self-checking testbench of the dual converter conversion control
`include "dacc_defines.svh"
`default_nettype none
module tb_dacc_top;
    timeunit 1ns;
    timeprecision 100ps;
    import dacc_pkg::*;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam int CC = 4; // Short conversion keeps the run brief
    logic                clk;
    logic                rst_n;
    logic                pd_n;
    logic                conv_start;
    logic                cfg_wr;
    logic [1:0]          cfg_sel;
    logic                cfg_cm;
    logic [15:0]         raw_a;
    logic [15:0]         raw_b;
    logic                isolate;
    logic                conv_done;
    dacc_state_type      state;
    logic signed [15:0]  data_a;
    logic signed [15:0]  data_b;
    logic                ready;
    logic [1:0]          avg_cfg;
    logic                cm_en;
    int                  err_count;
    int                  checks;

    dacc_top #(.RES(16), .CONV_CYCLES(CC)) i_dacc_top (
        .CLK_I(clk), .RST_N_I(rst_n), .CONV_START_I(conv_start), .POWERDOWN_RESET_N_I(pd_n),
        .CFG_WR_I(cfg_wr), .CFG_AVG_SEL_I(cfg_sel), .CFG_CM_OFS_EN_I(cfg_cm),
        .RAW_A_I(raw_a), .RAW_B_I(raw_b), .ISOLATE_O(isolate), .CONV_DONE_O(conv_done),
        .STATE_O(state), .DATA_A_O(data_a), .DATA_B_O(data_b), .READY_O(ready),
        .AVG_CFG_O(avg_cfg), .CM_OFFSET_EN_O(cm_en));

    dacc_host_model i_dacc_host_model (.clk_i(clk), .conv_start_o(conv_start));

    // Free-running 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Compare and closing tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        if (err_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        cmp_val({15'h0000, got}, {15'h0000, exp}, what);
    endtask

    // ----------------------------------------------------------------
    // Stimulus helpers
    // ----------------------------------------------------------------
    // Reset by either pin; all outputs but the done flag must be cleared while it is held
    task automatic do_reset(input bit use_pd, input int cycles);
        if (use_pd)
            pd_n = 1'b0;
        else
            rst_n = 1'b0;
        repeat (cycles) @(negedge clk);
        cmp_val(16'(state), 16'(DACC_ST_RST), "reset state");
        cmp_bit(isolate, 1'b0, "isolate in reset");
        cmp_bit(ready, 1'b0, "ready in reset");
        cmp_val(data_a, 16'h0000, "data in reset");
        cmp_val(data_b, 16'h0000, "data b in reset");
        cmp_val(16'(avg_cfg), 16'(`DACC_AVG_CFG_RST), "avg cfg in reset");
        cmp_bit(cm_en, `DACC_CM_OFS_RST, "offset in reset");
        rst_n = 1'b1;
        pd_n = 1'b1;
        repeat (2) @(negedge clk);
        cmp_val(16'(state), 16'(DACC_ST_ACQ), "state after reset");
    endtask

    task automatic cfg(input logic [1:0] sel, input logic cm);
        cfg_sel = sel;
        cfg_cm = cm;
        cfg_wr = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
        cmp_val(16'(avg_cfg), 16'(sel), "avg cfg");
        cmp_bit(cm_en, cm, "offset enable");
    endtask

    // One conversion; extra fires a second start while converting, which must be ignored
    task automatic conv(input logic [15:0] ra, input logic [15:0] rb, input bit last,
                        input logic [15:0] ea, input logic [15:0] eb, input bit extra);
        int n;
        int i;
        n = 0;
        raw_a = ra;
        raw_b = rb;
        i_dacc_host_model.pulse(1);
        for (i = 0; i < 40; i++) begin
            if (isolate === 1'b1) begin
                n++;
                if (extra && n == 2) begin
                    fork
                        i_dacc_host_model.pulse(0);
                    join_none
                end
            end else if (n > 0) begin
                break;
            end
            @(negedge clk);
        end
        if (i == 40) begin
            err_count++;
            $display("mismatch at %0t: conversion timed out", $time);
            give_verdict();
        end
        cmp_val(16'(n), 16'(CC), "isolate cycles");
        cmp_bit(conv_done, 1'b1, "done at reconnect");
        cmp_val(16'(state), 16'(DACC_ST_ACQ), "state at done");
        @(negedge clk);
        cmp_bit(conv_done, 1'b0, "done width");
        if (last) begin
            cmp_val(data_a, ea, "data a");
            cmp_val(data_b, eb, "data b");
        end
        @(negedge clk);
        cmp_bit(ready, last, "ready");
        cmp_bit(isolate, 1'b0, "no queued start");
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_codes();
        conv(16'h0000, 16'hFFFF, 1'b1, 16'h8000, 16'h7FFF, 1'b0);
        conv(16'h8000, 16'h7FFF, 1'b1, 16'h0000, 16'hFFFF, 1'b0);
    endtask

    task automatic test_avg2();
        cfg(`DACC_AVG_TWO, 1'b0);
        conv(16'h8001, 16'h0000, 1'b0, 16'h0000, 16'h0000, 1'b0);
        conv(16'h8002, 16'h0000, 1'b1, 16'h0001, 16'h8000, 1'b0);
    endtask

    // Codes -3, 1, 2, -1 sum to -1; quarter rounds down to -1
    task automatic test_avg4();
        cfg(`DACC_AVG_FOUR, 1'b1);
        conv(16'h7FFD, 16'hFFFF, 1'b0, 16'h0000, 16'h0000, 1'b0);
        conv(16'h8001, 16'hFFFF, 1'b0, 16'h0000, 16'h0000, 1'b0);
        conv(16'h8002, 16'hFFFF, 1'b0, 16'h0000, 16'h0000, 1'b0);
        conv(16'h7FFF, 16'hFFFF, 1'b1, 16'hFFFF, 16'h7FFF, 1'b0);
    endtask

    task automatic test_other_codes();
        for (int c = 0; c < 2; c++) begin
            cfg(2'(c), 1'b0);
            conv(16'h8003, 16'h7FFE, 1'b1, 16'h0003, 16'hFFFE, 1'b0);
        end
    endtask

    task automatic test_ignored_start();
        conv(16'h8005, 16'h8006, 1'b1, 16'h0005, 16'h0006, 1'b1);
    endtask

    // Power-down mid-conversion aborts it and restores defaults
    task automatic test_abort();
        cfg(`DACC_AVG_FOUR, 1'b1);
        i_dacc_host_model.pulse(1);
        @(negedge clk);
        cmp_bit(isolate, 1'b1, "converting");
        do_reset(1'b1, 2);
        conv(16'h8007, 16'h8008, 1'b1, 16'h0007, 16'h0008, 1'b0);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        err_count = 0;
        checks = 0;
        rst_n = 1'b0;
        pd_n = 1'b1;
        cfg_wr = 1'b0;
        cfg_sel = 2'h0;
        cfg_cm = 1'b0;
        raw_a = 16'h0000;
        raw_b = 16'h0000;
        do_reset(1'b0, 10);
        test_codes();
        test_avg2();
        test_avg4();
        test_other_codes();
        test_ignored_start();
        test_abort();
        give_verdict();
    end
endmodule
`default_nettype wire
